// ===== sepp_pkg.sv
package sepp_pkg;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam int unsigned BIT_CNT_W = 6;
  localparam logic [5:0] BITS_OP = 6'h08;
  localparam logic [5:0] BITS_STATUS_WR = 6'h10;
  localparam logic [5:0] BITS_WRITE = 6'h20;
  localparam logic [5:0] CNT_RESET = 6'h00;
  localparam logic [7:0] SR_RESET = 8'h00;
  localparam int unsigned SR_LATCH_POS = 1;
  localparam int unsigned SR_BUSY_POS = 0;
  localparam logic [11:0] WRITE_CYCLES = 12'h0fa;
  localparam logic [3:0] SCK_HALF_DIV = 4'h4;
  typedef enum logic [1:0]
  {
    HST_IDLE = 2'b00,
    HST_SHIFT = 2'b01,
    HST_PAUSE = 2'b10,
    HST_END = 2'b11
  } sepp_host_state_e;
endpackage : sepp_pkg

// ===== sepp_if.sv
`timescale 1ns/100ps
interface sepp_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic hold_n;
  modport dev
  (
    input sck,
    input cs_n,
    input si,
    input hold_n,
    output so,
    output so_oe
  );
  modport host
  (
    output sck,
    output cs_n,
    output si,
    output hold_n,
    input so,
    input so_oe
  );
endinterface : sepp_if

// ===== sepp_dev.sv
`timescale 1ns/100ps
module sepp_dev
(
  sepp_if.dev bus,
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  output logic latch_out,
  output logic busy_out,
  output logic standby_out
);
  logic [5:0] cnt_reg;
  logic [7:0] op_reg;
  logic [7:0] sh_reg;
  logic [7:0] sr_reg;
  logic latch_reg;
  logic armed_reg;
  logic so_reg;
  logic so_oe_reg;
  logic wr_req_tgl_reg;
  logic wr_done_s1_reg;
  logic wr_done_s2_reg;
  logic wr_done_s3_reg;
  logic busy_lnk;
  logic [11:0] wcnt_reg;
  logic busy_reg;
  logic done_tgl_reg;
  logic req_s1_reg;
  logic req_s2_reg;
  logic req_s3_reg;
  logic latch_s1_reg;
  logic latch_s2_reg;
  logic cs_s1_reg;
  logic cs_s2_reg;
  wire paused = ~bus.hold_n;
  wire op_done = (cnt_reg == sepp_pkg::BITS_OP);
  wire [7:0] op_now = {sh_reg[6:0], bus.si};
  wire is_status_rd = (op_reg == sepp_pkg::OP_STATUS_READ);
  wire busy_gate = busy_lnk & ~is_status_rd;
  wire known_op = (op_reg == sepp_pkg::OP_WR_ENABLE) |
    (op_reg == sepp_pkg::OP_WR_DISABLE) | is_status_rd |
    (op_reg == sepp_pkg::OP_WRITE) | (op_reg == sepp_pkg::OP_READ) |
    (op_reg == sepp_pkg::OP_STATUS_WRITE);
  // Status read answers once its eighth bit is in
  wire answer = op_done & is_status_rd & known_op;
  // Pause or deselect floats the output at once, with no clock edge
  wire oe_clr = bus.cs_n | ~bus.hold_n;
  // Writes commit only on a whole-byte boundary
  wire wr_ok = latch_reg & ~busy_lnk & (
    ((op_reg == sepp_pkg::OP_STATUS_WRITE) &
      (cnt_reg == sepp_pkg::BITS_STATUS_WR)) |
    ((op_reg == sepp_pkg::OP_WRITE) & (cnt_reg >= sepp_pkg::BITS_WRITE) &
      (cnt_reg[2:0] == 3'h0)));
  // Link-side handshake state that must survive deselect
  assign busy_lnk = wr_req_tgl_reg ^ wr_done_s3_reg;
  // Shift path on the link clock; async clear by select high
  always_ff @(posedge bus.sck or posedge bus.cs_n)
  begin
    if (bus.cs_n)
    begin
      cnt_reg <= sepp_pkg::CNT_RESET;
      sh_reg <= 8'h00;
      op_reg <= 8'h00;
    end
    else if (!paused)
    begin
      sh_reg <= op_now;
      if (cnt_reg != 6'h3f)
        cnt_reg <= cnt_reg + 6'h01;
      if (cnt_reg == sepp_pkg::BITS_OP - 6'h01)
        op_reg <= op_now;
    end
  end
  // Output bit launched on the falling clock edge
  always_ff @(negedge bus.sck or posedge bus.cs_n)
  begin
    if (bus.cs_n)
      so_reg <= 1'b0;
    else if (!paused & answer)
      so_reg <= sr_reg[7];
  end
  // Enable set on the falling edge, cleared by pause or deselect
  always_ff @(negedge bus.sck or posedge oe_clr)
  begin
    if (oe_clr)
      so_oe_reg <= 1'b0;
    else if (answer)
      so_oe_reg <= 1'b1;
  end
  // Select rising edge commits instructions (edge of the frame)
  always_ff @(posedge bus.cs_n or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      latch_reg <= 1'b0;
      wr_req_tgl_reg <= 1'b0;
    end
    else if (armed_reg & op_done & ~busy_gate)
    begin
      if (op_reg == sepp_pkg::OP_WR_ENABLE)
        latch_reg <= 1'b1;
      else if (op_reg == sepp_pkg::OP_WR_DISABLE)
        latch_reg <= 1'b0;
    end
    else if (armed_reg & wr_ok)
    begin
      latch_reg <= 1'b0;
      wr_req_tgl_reg <= ~wr_req_tgl_reg;
    end
  end
  // Armed only after the first select low following reset
  always_ff @(negedge bus.cs_n or negedge resetn_in)
  begin
    if (!resetn_in)
      armed_reg <= 1'b0;
    else
      armed_reg <= 1'b1;
  end
  // Write-done toggle brought onto the link clock; a frame has 8 or 16 rises
  always_ff @(posedge bus.sck or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_done_s1_reg <= 1'b0;
      wr_done_s2_reg <= 1'b0;
      wr_done_s3_reg <= 1'b0;
    end
    else
    begin
      wr_done_s1_reg <= done_tgl_reg;
      wr_done_s2_reg <= wr_done_s1_reg;
      wr_done_s3_reg <= wr_done_s2_reg;
    end
  end
  // Status shown on the link; busy bit mirrors the handshake
  always_comb
  begin
    sr_reg = sepp_pkg::SR_RESET;
    sr_reg[sepp_pkg::SR_LATCH_POS] = latch_reg;
    sr_reg[sepp_pkg::SR_BUSY_POS] = busy_lnk;
  end
  assign bus.so = so_reg;
  assign bus.so_oe = so_oe_reg;
  // System clock side: self-timed write cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      wcnt_reg <= 12'h000;
      busy_reg <= 1'b0;
      done_tgl_reg <= 1'b0;
      latch_s1_reg <= 1'b0;
      latch_s2_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      latch_out <= 1'b0;
      busy_out <= 1'b0;
      standby_out <= 1'b1;
    end
    else if (ce_in)
    begin
      req_s1_reg <= wr_req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      latch_s1_reg <= latch_reg;
      latch_s2_reg <= latch_s1_reg;
      cs_s1_reg <= bus.cs_n;
      cs_s2_reg <= cs_s1_reg;
      latch_out <= latch_s2_reg;
      busy_out <= busy_reg;
      standby_out <= cs_s2_reg & ~busy_reg;
      if (req_s2_reg ^ req_s3_reg)
      begin
        busy_reg <= 1'b1;
        wcnt_reg <= sepp_pkg::WRITE_CYCLES;
      end
      else if (busy_reg)
      begin
        if (wcnt_reg == 12'h000)
        begin
          busy_reg <= 1'b0;
          done_tgl_reg <= ~done_tgl_reg;
        end
        else
          wcnt_reg <= wcnt_reg - 12'h001;
      end
    end
  end
endmodule : sepp_dev

// ===== sepp_host.sv
`timescale 1ns/100ps
module sepp_host
(
  sepp_if.host bus,
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [7:0] op_in,
  input wire logic pause_in,
  output logic done_out,
  output logic [7:0] rx_out
);
  sepp_pkg::sepp_host_state_e st_reg;
  logic [3:0] div_reg;
  logic sck_reg;
  logic cs_reg;
  logic si_reg;
  logic hold_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [5:0] bits_reg;
  logic [5:0] len_reg;
  logic so_s1_reg;
  logic so_s2_reg;
  logic pause_s1_reg;
  logic pause_s2_reg;
  wire tick = (div_reg == sepp_pkg::SCK_HALF_DIV);
  wire low_phase = ~sck_reg;
  // Status write frames carry a data byte; all others are opcode only
  wire [5:0] len_sel = (op_in == sepp_pkg::OP_STATUS_WRITE) ?
    sepp_pkg::BITS_STATUS_WR : sepp_pkg::BITS_OP;
  assign bus.sck = sck_reg;
  assign bus.cs_n = cs_reg;
  assign bus.si = si_reg;
  assign bus.hold_n = hold_reg;
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_reg <= sepp_pkg::HST_IDLE;
      div_reg <= 4'h0;
      sck_reg <= 1'b0;
      cs_reg <= 1'b1;
      si_reg <= 1'b0;
      hold_reg <= 1'b1;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      bits_reg <= 6'h00;
      len_reg <= sepp_pkg::BITS_OP;
      so_s1_reg <= 1'b0;
      so_s2_reg <= 1'b0;
      pause_s1_reg <= 1'b0;
      pause_s2_reg <= 1'b0;
      done_out <= 1'b0;
      rx_out <= 8'h00;
    end
    else if (ce_in)
    begin
      so_s1_reg <= bus.so;
      so_s2_reg <= so_s1_reg;
      pause_s1_reg <= pause_in;
      pause_s2_reg <= pause_s1_reg;
      done_out <= 1'b0;
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
      case (st_reg)
        sepp_pkg::HST_IDLE:
          if (start_in)
          begin
            cs_reg <= 1'b0;
            tx_reg <= op_in;
            bits_reg <= 6'h00;
            len_reg <= len_sel;
            st_reg <= sepp_pkg::HST_SHIFT;
          end
        sepp_pkg::HST_SHIFT:
          if (tick)
          begin
            if (low_phase & pause_s2_reg)
            begin
              hold_reg <= 1'b0;
              st_reg <= sepp_pkg::HST_PAUSE;
            end
            else if (low_phase & (bits_reg == len_reg))
              st_reg <= sepp_pkg::HST_END;
            else if (low_phase)
            begin
              si_reg <= tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              sck_reg <= 1'b1;
            end
            else
            begin
              rx_reg <= {rx_reg[6:0], so_s2_reg};
              bits_reg <= bits_reg + 6'h01;
              sck_reg <= 1'b0;
            end
          end
        sepp_pkg::HST_PAUSE:
          if (tick & ~pause_s2_reg)
          begin
            hold_reg <= 1'b1;
            st_reg <= sepp_pkg::HST_SHIFT;
          end
        sepp_pkg::HST_END:
          if (tick)
          begin
            cs_reg <= 1'b1;
            done_out <= 1'b1;
            rx_out <= rx_reg;
            st_reg <= sepp_pkg::HST_IDLE;
          end
        default:
          st_reg <= sepp_pkg::HST_IDLE;
      endcase
    end
  end
endmodule : sepp_host

// ===== sepp_chk_sva.sv
`timescale 1ns/100ps
module sepp_chk
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic hold_n
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  logic sck_d;
  logic [5:0] rise_cnt;
  wire sck_rise = sck & ~sck_d;
  // Clock rises seen in the current frame
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sck_d <= 1'b0;
      rise_cnt <= 6'h00;
    end
    else
    begin
      sck_d <= sck;
      rise_cnt <= cs_n ? 6'h00 : rise_cnt + {5'h00, sck_rise};
    end
  end
  pause_enter_a: assert property ($fell(hold_n) |-> !sck)
    else $error("pause entered with clock high");
  pause_select_a: assert property (!hold_n |-> !cs_n)
    else $error("deselected during pause");
  pause_float_a: assert property (!hold_n ##1 !hold_n |-> !so_oe)
    else $error("output driven during pause");
  pause_exit_a: assert property ($rose(hold_n) |-> !sck)
    else $error("pause left with clock high");
  reset_state_a: assert property
    ($rose(resetn_in) |-> cs_n && hold_n && !sck && !so_oe)
    else $error("link not idle after reset");
  idle_float_a: assert property (cs_n ##1 cs_n |-> !so_oe)
    else $error("output driven while deselected");
  pause_freeze_a: assert property (!hold_n ##1 !hold_n |-> $stable(sck))
    else $error("clock moved during pause");
  frame_len_a: assert property
    ($rose(cs_n) |-> rise_cnt == 6'h08 || rise_cnt == 6'h10)
    else $error("frame length not a whole byte count");
  cover property ($fell(hold_n));
  cover property ($rose(cs_n) && rise_cnt == 6'h10);
  cover property ($rose(cs_n));
  cover property ($rose(so_oe));
endmodule : sepp_chk

// ===== serial_eeprom_pause_and_power_state_test.sv
`timescale 1ns/100ps
module serial_eeprom_pause_and_power_state_test;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic start_in = 1'b0;
  logic pause_in = 1'b0;
  logic [7:0] op_in = 8'h00;
  logic done_out, latch_out, busy_out, standby_out;
  logic [7:0] rx_out;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int paused = 0;
  int oe_cnt = 0;
  int oe_base = 0;
  sepp_if bus_if();
  sepp_host i_sepp_host(.bus(bus_if.host), .clk_sys_in, .resetn_in,
    .ce_in(1'b1), .start_in, .op_in, .pause_in, .done_out, .rx_out);
  sepp_dev i_sepp_dev(.bus(bus_if.dev), .clk_sys_in, .resetn_in,
    .ce_in(1'b1), .latch_out, .busy_out, .standby_out);
  sepp_chk i_sepp_chk(.clk_sys_in, .resetn_in, .sck(bus_if.sck),
    .cs_n(bus_if.cs_n), .si(bus_if.si), .so(bus_if.so),
    .so_oe(bus_if.so_oe), .hold_n(bus_if.hold_n));
  initial
  begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    if (bus_if.so_oe === 1'b1)
      oe_cnt <= oe_cnt + 1;
    if (bus_if.hold_n === 1'b0)
      paused <= paused + 1;
  end
  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok)
    begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic summarize;
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // One opcode frame, optionally paused for hold cycles mid-frame
  task automatic send(input logic [7:0] op, input int hold);
    int n;
    @(posedge clk_sys_in);
    #1 op_in = op;
    start_in = 1'b1;
    oe_base = oe_cnt;
    @(posedge clk_sys_in);
    #1 start_in = 1'b0;
    if (hold > 0)
    begin
      repeat (30) @(posedge clk_sys_in);
      #1 pause_in = 1'b1;
      repeat (hold) @(posedge clk_sys_in);
      #1 pause_in = 1'b0;
    end
    n = 0;
    while (done_out !== 1'b1 && n < 600)
    begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    chk(n < 600, "frame never finished");
    repeat (12) @(posedge clk_sys_in);
    #1;
  endtask : send
  task automatic t_power;
    chk(latch_out === 1'b0, "latch set at power up");
    chk(busy_out === 1'b0, "busy at power up");
    chk(standby_out === 1'b1, "not in standby");
  endtask : t_power
  task automatic t_enable;
    send(sepp_pkg::OP_WR_ENABLE, 0);
    chk(latch_out === 1'b1, "enable did not set latch");
    chk(standby_out === 1'b1, "no standby after frame");
  endtask : t_enable
  task automatic t_unknown;
    send(8'h5a, 0);
    chk(oe_cnt == oe_base, "unknown opcode drove output");
    chk(latch_out === 1'b1, "unknown opcode changed latch");
  endtask : t_unknown
  task automatic t_short_write;
    send(sepp_pkg::OP_WRITE, 0);
    chk(busy_out === 1'b0, "short write started cycle");
    chk(latch_out === 1'b1, "failed write cleared latch");
  endtask : t_short_write
  // Full status write, then enable and status read while it runs
  task automatic t_write;
    int n;
    send(sepp_pkg::OP_STATUS_WRITE, 0);
    chk(busy_out === 1'b1, "write cycle not started");
    chk(latch_out === 1'b0, "write left latch set");
    chk(standby_out === 1'b0, "standby while writing");
    send(sepp_pkg::OP_WR_ENABLE, 0);
    chk(latch_out === 1'b0, "enable taken while busy");
    send(sepp_pkg::OP_STATUS_READ, 0);
    chk(oe_cnt > oe_base, "status read refused while busy");
    n = 0;
    while (busy_out !== 1'b0 && n < 400)
    begin
      @(posedge clk_sys_in);
      #1 n++;
    end
    chk(n < 400, "write cycle never ended");
    send(sepp_pkg::OP_WR_ENABLE, 0);
    chk(latch_out === 1'b1, "enable refused after write");
  endtask : t_write
  task automatic t_pause;
    int p0;
    send(sepp_pkg::OP_WR_DISABLE, 0);
    chk(latch_out === 1'b0, "disable did not clear latch");
    p0 = paused;
    send(sepp_pkg::OP_WR_ENABLE, 120);
    chk(paused > p0, "pause never reached the link");
    chk(latch_out === 1'b1, "paused frame lost its bits");
  endtask : t_pause
  task automatic t_status;
    send(sepp_pkg::OP_STATUS_READ, 0);
    chk(oe_cnt > oe_base, "status read not answered");
    chk(rx_out[7] === 1'b0, "status top bit wrong");
  endtask : t_status
  // Supply drop in mid-run, then a fresh start
  task automatic t_reset;
    @(posedge clk_sys_in);
    #1 resetn_in = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #1;
    chk(latch_out === 1'b0, "latch kept through reset");
    chk(standby_out === 1'b1, "no standby in reset");
    resetn_in = 1'b1;
    send(sepp_pkg::OP_WR_ENABLE, 0);
    chk(latch_out === 1'b1, "no instruction after restart");
  endtask : t_reset
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    #1 resetn_in = 1'b1;
    t_power();
    t_enable();
    t_unknown();
    t_short_write();
    t_write();
    t_pause();
    t_status();
    t_reset();
    summarize();
  end
endmodule : serial_eeprom_pause_and_power_state_test
